/* File: core/drc_pkg.sv */
package drc_pkg;
  // ==========================================
  // Timing figures in nanoseconds, plus row counts and bus widths.
  localparam int CLK_PERIOD_NS = 8;
  localparam int POWERUP_WAIT_NS = 100000;
  localparam int INIT_ROW_CYCLES = 8;
  localparam int RANDOM_CYCLE_PERIOD_NS_FAST = 260;
  localparam int RANDOM_CYCLE_PERIOD_NS_SLOW = 330;
  localparam int READ_WRITE_CYCLE_PERIOD_NS_FAST = 325;
  localparam int READ_WRITE_CYCLE_PERIOD_NS_SLOW = 410;
  localparam int PAGE_CYCLE_PERIOD_NS_FAST = 145;
  localparam int PAGE_CYCLE_PERIOD_NS_SLOW = 190;
  localparam int ROW_ACCESS_LATENCY_NS_FAST = 150;
  localparam int ROW_ACCESS_LATENCY_NS_SLOW = 200;
  localparam int COLUMN_ACCESS_LATENCY_NS_FAST = 75;
  localparam int COLUMN_ACCESS_LATENCY_NS_SLOW = 100;
  localparam int ROW_TO_COLUMN_DELAY_MIN_NS_FAST = 25;
  localparam int ROW_TO_COLUMN_DELAY_MIN_NS_SLOW = 30;
  localparam int ROW_TO_COLUMN_DELAY_MAX_NS_FAST = 75;
  localparam int ROW_TO_COLUMN_DELAY_MAX_NS_SLOW = 100;
  localparam int OUTPUT_RELEASE_DELAY_NS_FAST = 40;
  localparam int OUTPUT_RELEASE_DELAY_NS_SLOW = 50;
  localparam int WRITE_LEAD_NS_FAST = 60;
  localparam int WRITE_LEAD_NS_SLOW = 80;
  localparam int REFRESH_INTERVAL_NS = 4000000;
  localparam int REFRESH_ROWS = 256;
  localparam int ROW_PRECHARGE_NS_FAST = 100;
  localparam int ROW_PRECHARGE_NS_SLOW = 120;
  localparam int STROBE_MAX_WIDTH_NS = 10000;
  localparam int ADDR_W = 9;
  localparam int CELL_ADDR_W = 18;
  localparam int CNT_W = 16;

  // ==========================================
  // Cycle counts derived from the clock period.
  function automatic int ns_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int ns_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int POWERUP_WAIT_CYC = ns_min(POWERUP_WAIT_NS);
  localparam int REFRESH_SPACING_CYC = ns_max(REFRESH_INTERVAL_NS / REFRESH_ROWS);
  localparam int STROBE_MAX_CYC = ns_max(STROBE_MAX_WIDTH_NS);

  typedef enum logic [3:0] {
    DRC_POWERUP = 4'h0,
    DRC_IDLE = 4'h1,
    DRC_RAS = 4'h2,
    DRC_CAS = 4'h3,
    DRC_WAIT = 4'h4,
    DRC_RMW_WR = 4'h5,
    DRC_PAGE_PRE = 4'h6,
    DRC_RAS_END = 4'h7,
    DRC_PRE = 4'h8
  } drc_state_t;
endpackage

/* File: core/drc_timer_if.sv */
`timescale 1ns/100ps
interface drc_timer_if;
  logic load;
  logic [drc_pkg::CNT_W-1:0] value;
  logic done;
  modport master (output load, output value, input done);
  modport timer (input load, input value, output done);
endinterface

/* File: core/drc_timer.sv */
`timescale 1ns/100ps
module drc_timer (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  drc_timer_if.timer tif
);
  import drc_pkg::*;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    if (tif.load) begin
      cnt_d = tif.value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 16'h0001;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tif.done = (cnt_q == '0);
endmodule

/* File: core/drc_ctrl.sv */
`timescale 1ns/100ps
// Summary of operation
// - Wait 100 us, then eight row cycles.
// - Random cycles spaced by the cycle period.
// - Read-write cycles take the longer period.
// - Page column cycles spaced by page period.
// - Column strobe falls inside the delay window.
// - Write strobe leads both strobe rises.
// - Refresh all 256 rows every 4 ms.
// - Write strobe high reads, low writes.
// - Row then column address multiplexed.
module drc_ctrl #(
  parameter bit SLOW_GRADE = 1'b0,
  parameter int POWERUP_CYC = drc_pkg::POWERUP_WAIT_CYC,
  parameter int REFRESH_CYC = drc_pkg::REFRESH_SPACING_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_rmw,
  input wire logic [drc_pkg::CELL_ADDR_W-1:0] i_req_addr,
  input wire logic i_req_wdata,
  input wire logic i_req_page,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic o_rdata,
  output logic o_init_done,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [drc_pkg::ADDR_W-1:0] o_muxed_addr_bus,
  output logic o_din,
  input wire logic i_dout
);
  import drc_pkg::*;

  if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << CNT_W) || REFRESH_CYC < 64 ||
      REFRESH_CYC > (1 << CNT_W)) begin : g_bad_timing
    $error("drc_ctrl: unsupported timing parameters");
  end

  // ==========================================
  // Grade-dependent cycle counts.
  localparam int RAS_CYC = ns_min(SLOW_GRADE ? ROW_TO_COLUMN_DELAY_MIN_NS_SLOW
                                             : ROW_TO_COLUMN_DELAY_MIN_NS_FAST);
  localparam int CAS_CYC = ns_min(SLOW_GRADE ? COLUMN_ACCESS_LATENCY_NS_SLOW
                                             : COLUMN_ACCESS_LATENCY_NS_FAST) + 1;
  localparam int RAC_CYC = ns_min(SLOW_GRADE ? ROW_ACCESS_LATENCY_NS_SLOW
                                             : ROW_ACCESS_LATENCY_NS_FAST) + 1;
  localparam int LEAD_CYC = ns_min(SLOW_GRADE ? WRITE_LEAD_NS_SLOW : WRITE_LEAD_NS_FAST);
  localparam int PC_CYC = ns_min(SLOW_GRADE ? PAGE_CYCLE_PERIOD_NS_SLOW
                                            : PAGE_CYCLE_PERIOD_NS_FAST);
  localparam int RC_CYC = ns_min(SLOW_GRADE ? RANDOM_CYCLE_PERIOD_NS_SLOW
                                            : RANDOM_CYCLE_PERIOD_NS_FAST);
  localparam int RWC_CYC = ns_min(SLOW_GRADE ? READ_WRITE_CYCLE_PERIOD_NS_SLOW
                                             : READ_WRITE_CYCLE_PERIOD_NS_FAST);
  localparam int RP_CYC = ns_min(SLOW_GRADE ? ROW_PRECHARGE_NS_SLOW : ROW_PRECHARGE_NS_FAST);
  localparam int OFF_CYC = ns_min(SLOW_GRADE ? OUTPUT_RELEASE_DELAY_NS_SLOW
                                             : OUTPUT_RELEASE_DELAY_NS_FAST);
  localparam int CP_CYC = (PC_CYC - CAS_CYC > OFF_CYC) ? PC_CYC - CAS_CYC : OFF_CYC;

  // ==========================================
  // Input pin synchroniser.
  logic dout_meta_q;
  logic dout_sync_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_meta_q <= 1'b0;
      dout_sync_q <= 1'b0;
    end else begin
      dout_meta_q <= i_dout;
      dout_sync_q <= dout_meta_q;
    end
  end

  // ==========================================
  // Cycle timer.
  drc_timer_if tif ();
  drc_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .tif(tif)
  );

  // ==========================================
  // Power-up wait, loaded once on the first cycle out of reset.
  logic started_q;
  logic pu_load;
  assign pu_load = !started_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // ==========================================
  // Sequencer.
  drc_state_t state_q, state_d;
  logic ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d, din_q, din_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [ADDR_W-1:0] col_q, col_d;
  logic [7:0] ref_row_q, ref_row_d;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic init_done_q, init_done_d;
  logic is_ref_q, is_ref_d, is_wr_q, is_wr_d, is_rmw_q, is_rmw_d;
  logic rvalid_q, rvalid_d, rdata_q, rdata_d;
  logic [15:0] ref_tmr_q, ref_tmr_d;
  logic ref_pend_q, ref_pend_d;
  logic [15:0] ras_age_q, ras_age_d;
  logic accept;

  assign o_req_ready = ((state_q == DRC_IDLE) && init_done_q && !ref_pend_q) ||
                       ((state_q == DRC_PAGE_PRE) && tif.done);
  assign accept = o_req_ready && i_req_valid;

  always_comb begin
    state_d = state_q;
    ras_n_d = ras_n_q;
    cas_n_d = cas_n_q;
    we_n_d = we_n_q;
    din_d = din_q;
    addr_d = addr_q;
    col_d = col_q;
    ref_row_d = ref_row_q;
    init_cnt_d = init_cnt_q;
    init_done_d = init_done_q;
    is_ref_d = is_ref_q;
    is_wr_d = is_wr_q;
    is_rmw_d = is_rmw_q;
    rvalid_d = 1'b0;
    rdata_d = rdata_q;
    tif.load = 1'b0;
    tif.value = '0;
    ref_pend_d = ref_pend_q;
    ref_tmr_d = ref_tmr_q;
    ras_age_d = ras_n_q ? 16'h0000 : ras_age_q + 16'h0001;
    if (ref_tmr_q == 16'h0000) begin
      ref_tmr_d = 16'(REFRESH_CYC - 1);
      ref_pend_d = init_done_q;
    end else begin
      ref_tmr_d = ref_tmr_q - 16'h0001;
    end
    case (state_q)
      DRC_POWERUP: begin
        if (tif.done && started_q) begin
          state_d = DRC_IDLE;
        end
      end
      DRC_IDLE: begin
        if (!init_done_q || ref_pend_q) begin
          // Row-only cycle: refresh or power-up warm-up, column strobe stays high.
          is_ref_d = 1'b1;
          if (ref_tmr_q != 16'h0000 && init_done_q) begin
            ref_pend_d = 1'b0;
          end
          addr_d = {1'b0, ref_row_q};
          ref_row_d = ref_row_q + 8'h01;
          ras_n_d = 1'b0;
          tif.load = 1'b1;
          tif.value = 16'(RAC_CYC);
          state_d = DRC_RAS_END;
        end else if (accept) begin
          is_ref_d = 1'b0;
          is_wr_d = i_req_write;
          is_rmw_d = i_req_rmw && !i_req_write;
          we_n_d = !(i_req_write);
          din_d = i_req_wdata;
          addr_d = i_req_addr[CELL_ADDR_W-1:ADDR_W];
          col_d = i_req_addr[ADDR_W-1:0];
          ras_n_d = 1'b0;
          tif.load = 1'b1;
          tif.value = 16'(RAS_CYC);
          state_d = DRC_RAS;
        end
      end
      DRC_RAS: begin
        addr_d = col_q;
        if (tif.done) begin
          cas_n_d = 1'b0;
          tif.load = 1'b1;
          tif.value = 16'((RAC_CYC - RAS_CYC > CAS_CYC)
                          ? RAC_CYC - RAS_CYC : CAS_CYC);
          state_d = DRC_CAS;
        end
      end
      DRC_CAS: begin
        if (tif.done) begin
          // Early writes never sample; reads sample after both latencies.
          if (!is_wr_q) begin
            rdata_d = dout_sync_q;
            rvalid_d = 1'b1;
          end
          if (is_rmw_q) begin
            we_n_d = 1'b0;
            din_d = !dout_sync_q;
            tif.load = 1'b1;
            tif.value = 16'(LEAD_CYC);
            state_d = DRC_RMW_WR;
          end else begin
            tif.load = 1'b1;
            tif.value = 16'(LEAD_CYC);
            state_d = DRC_WAIT;
          end
        end
      end
      DRC_RMW_WR, DRC_WAIT: begin
        if (tif.done) begin
          cas_n_d = 1'b1;
          if (i_req_page && !is_rmw_q && i_req_valid && !ref_pend_q &&
              ras_age_q < 16'(STROBE_MAX_CYC / 2)) begin
            tif.load = 1'b1;
            tif.value = 16'(CP_CYC);
            state_d = DRC_PAGE_PRE;
          end else begin
            ras_n_d = 1'b1;
            tif.load = 1'b1;
            tif.value = 16'(is_rmw_q ? RWC_CYC : RC_CYC);
            state_d = DRC_PRE;
          end
        end
      end
      DRC_PAGE_PRE: begin
        we_n_d = 1'b1;
        if (tif.done) begin
          if (i_req_valid) begin
            is_wr_d = i_req_write;
            is_rmw_d = 1'b0;
            we_n_d = !i_req_write;
            din_d = i_req_wdata;
            addr_d = i_req_addr[ADDR_W-1:0];
            cas_n_d = 1'b0;
            tif.load = 1'b1;
            tif.value = 16'(CAS_CYC);
            state_d = DRC_CAS;
          end else begin
            ras_n_d = 1'b1;
            tif.load = 1'b1;
            tif.value = 16'(RP_CYC);
            state_d = DRC_PRE;
          end
        end
      end
      DRC_RAS_END: begin
        if (tif.done) begin
          ras_n_d = 1'b1;
          tif.load = 1'b1;
          tif.value = 16'(RC_CYC - RAC_CYC);
          state_d = DRC_PRE;
          if (!init_done_q) begin
            init_cnt_d = init_cnt_q + 4'h1;
            init_done_d = (init_cnt_q == 4'(INIT_ROW_CYCLES - 1));
          end
        end
      end
      DRC_PRE: begin
        we_n_d = 1'b1;
        if (tif.done) begin
          state_d = DRC_IDLE;
        end
      end
      default: begin
        state_d = DRC_IDLE;
      end
    endcase
    if (pu_load) begin
      tif.load = 1'b1;
      tif.value = 16'(POWERUP_CYC);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= DRC_POWERUP;
      ras_n_q <= 1'b1;
      cas_n_q <= 1'b1;
      we_n_q <= 1'b1;
      din_q <= 1'b0;
      addr_q <= '0;
      col_q <= '0;
      ref_row_q <= 8'h00;
      init_cnt_q <= 4'h0;
      init_done_q <= 1'b0;
      is_ref_q <= 1'b0;
      is_wr_q <= 1'b0;
      is_rmw_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 1'b0;
      ref_tmr_q <= 16'h0001;
      ref_pend_q <= 1'b0;
      ras_age_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      ras_n_q <= ras_n_d;
      cas_n_q <= cas_n_d;
      we_n_q <= we_n_d;
      din_q <= din_d;
      addr_q <= addr_d;
      col_q <= col_d;
      ref_row_q <= ref_row_d;
      init_cnt_q <= init_cnt_d;
      init_done_q <= init_done_d;
      is_ref_q <= is_ref_d;
      is_wr_q <= is_wr_d;
      is_rmw_q <= is_rmw_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      ref_tmr_q <= ref_tmr_d;
      ref_pend_q <= ref_pend_d;
      ras_age_q <= ras_age_d;
    end
  end

  assign o_ras_n = ras_n_q;
  assign o_cas_n = cas_n_q;
  assign o_we_n = we_n_q;
  assign o_muxed_addr_bus = addr_q;
  assign o_din = din_q;
  assign o_rdata_valid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_init_done = init_done_q;
endmodule

/* File: verification/drc_dram_model.sv */
`timescale 1ns/100ps
// ==========================================
// Behavioural memory device on the strobe pins.
module drc_dram_model (
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [drc_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_din,
  output logic o_dout
);
  import drc_pkg::*;
  logic mem [0:262143];
  logic [ADDR_W-1:0] row_q = '0;
  logic [CELL_ADDR_W-1:0] cell_q = '0;
  logic ok_q = 1'b0;
  logic bad_q = 1'b0;
  logic dat_q = 1'b0;
  logic col_q = 1'b0;
  realtime t_ras = 0.0;
  realtime t_cas = 0.0;
  realtime lat = 0.0;
  realtime t_we = 0.0;
  int ras_count = 0;
  int row_only = 0;
  initial begin
    for (int i = 0; i < 262144; i++) mem[i] = 1'b0;
  end
  always @(negedge i_ras_n) begin
    t_ras = $realtime;
    #1;
    row_q = i_addr;
    col_q = 1'b0;
    ras_count++;
  end
  always @(posedge i_ras_n) begin
    if (!col_q) row_only++;
  end
  always @(negedge i_cas_n) begin
    t_cas = $realtime;
    col_q = 1'b1;
    bad_q = 1'b0;
    #1;
    cell_q = {row_q, i_addr};
    if (!i_we_n) begin
      mem[cell_q] = i_din;
    end else begin
      lat = t_ras + ROW_ACCESS_LATENCY_NS_FAST - t_cas;
      if (lat < COLUMN_ACCESS_LATENCY_NS_FAST) lat = COLUMN_ACCESS_LATENCY_NS_FAST;
      #(lat - 1.0);
      if (!i_cas_n && !bad_q) begin
        dat_q = mem[cell_q];
        ok_q = 1'b1;
      end
    end
  end
  always @(negedge i_we_n) begin
    t_we = $realtime;
    #1;
    if (!i_cas_n && t_we > t_cas) begin
      mem[cell_q] = i_din;
      if (t_we - t_cas < 75.0 || t_we - t_ras < 150.0) bad_q = 1'b1;
    end
  end
  always @(posedge i_cas_n) begin
    ok_q = 1'b0;
  end
  assign o_dout = (ok_q && !bad_q) ? dat_q : ~dat_q;
endmodule

/* File: verification/drc_ctrl_checker.sv */
`timescale 1ns/100ps
// ==========================================
// Strobe timing checks at the memory pins.
module drc_ctrl_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic o_init_done,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n
);
  localparam int RCD_LO = 4;
  localparam int RCD_HI = 9;
  localparam int RC_MIN = 33;
  localparam int RWC_MIN = 41;
  localparam int PC_MIN = 19;
  localparam int LEAD_MIN = 7;
  localparam int WIDTH_MAX = 1250;
  logic [15:0] age_q, rgap_q, cgap_q, we_q;
  logic ras_p, cas_p, we_p, col_q, rw_q, ras_f, cas_f;
  assign ras_f = ras_p & ~o_ras_n;
  assign cas_f = cas_p & ~o_cas_n;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_q <= '0;
      rgap_q <= 16'hFFFF;
      cgap_q <= 16'hFFFF;
      we_q <= '0;
      ras_p <= 1'b1;
      cas_p <= 1'b1;
      we_p <= 1'b1;
      col_q <= 1'b0;
      rw_q <= 1'b0;
    end else begin
      age_q <= o_ras_n ? 16'h0 : age_q + 16'h1;
      rgap_q <= ras_f ? 16'h1 : rgap_q + {15'h0, ~&rgap_q};
      cgap_q <= cas_f ? 16'h1 : cgap_q + {15'h0, ~&cgap_q};
      we_q <= o_we_n ? 16'h0 : we_q + 16'h1;
      ras_p <= o_ras_n;
      cas_p <= o_cas_n;
      we_p <= o_we_n;
      col_q <= ~o_ras_n & (col_q | ~o_cas_n);
      rw_q <= ~ras_f & (rw_q | (~o_we_n & we_p & ~cas_p));
    end
  end
  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  AST_INIT_NO_COLUMN: assert property (!o_init_done |-> o_cas_n)
    else $error("Column strobe during initialisation");
  AST_RAS_TO_CAS: assert property (cas_f && !col_q |-> age_q inside {[RCD_LO:RCD_HI]})
    else $error("Row to column delay out of window");
  AST_RANDOM_CYCLE: assert property (ras_f |-> rgap_q >= RC_MIN)
    else $error("Random cycle too short");
  AST_RMW_CYCLE: assert property ($fell(o_ras_n) && rw_q |-> rgap_q >= RWC_MIN)
    else $error("Read-write cycle too short");
  AST_PAGE_CYCLE: assert property (cas_f && col_q |-> cgap_q >= PC_MIN)
    else $error("Page cycle too short");
  AST_WE_LEAD_CAS: assert property ($rose(o_cas_n) && !$past(o_we_n) |-> $past(we_q) >= LEAD_MIN)
    else $error("Write strobe lead before column rise too short");
  AST_WE_LEAD_RAS: assert property ($rose(o_ras_n) && !$past(o_we_n) |-> $past(we_q) >= LEAD_MIN)
    else $error("Write strobe lead before row rise too short");
  AST_STROBE_WIDTH: assert property (age_q < WIDTH_MAX)
    else $error("Row strobe held low too long");
endmodule
bind drc_ctrl drc_ctrl_checker chk_u (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .o_init_done(o_init_done),
  .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n)
);

/* File: verification/drc_ctrl_tb.sv */
`timescale 1ns/100ps
// ==========================================
// Self-checking bench with the memory model.
module drc_ctrl_tb;
  import drc_pkg::*;
  localparam logic [17:0] ADR_A = 18'h3F001;
  localparam logic [17:0] ADR_C = 18'h0A010;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req_valid = 1'b0;
  logic i_req_write = 1'b0;
  logic i_req_rmw = 1'b0;
  logic [CELL_ADDR_W-1:0] i_req_addr = '0;
  logic i_req_wdata = 1'b0;
  logic i_req_page = 1'b0;
  logic o_req_ready, o_rdata_valid, o_rdata, o_init_done, o_ras_n, o_cas_n, o_we_n, o_din, i_dout;
  logic [ADDR_W-1:0] o_muxed_addr_bus;
  logic rd_q[$];
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  always #(CLK_PERIOD_NS / 2) i_ref_clk = ~i_ref_clk;
  drc_ctrl #(.SLOW_GRADE(1'b0), .POWERUP_CYC(20), .REFRESH_CYC(200)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .i_req_rmw(i_req_rmw), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_req_page(i_req_page), .o_req_ready(o_req_ready),
    .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .o_init_done(o_init_done),
    .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
    .o_muxed_addr_bus(o_muxed_addr_bus), .o_din(o_din), .i_dout(i_dout)
  );
  drc_dram_model mem_u (
    .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n),
    .i_addr(o_muxed_addr_bus), .i_din(o_din), .o_dout(i_dout)
  );
  always @(posedge i_ref_clk) begin
    cyc++;
    if (o_rdata_valid === 1'b1) rd_q.push_back(o_rdata);
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $realtime, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic send(input logic wr, input logic rmw, input logic pg,
      input logic [CELL_ADDR_W-1:0] adr, input logic wd);
    i_req_valid = 1'b1;
    i_req_write = wr;
    i_req_rmw = rmw;
    i_req_page = pg;
    i_req_addr = adr;
    i_req_wdata = wd;
    for (int n = 0; n < 2000 && o_req_ready !== 1'b1; n++) tick(1);
    chk(o_req_ready, 1'b1);
    tick(1);
  endtask
  task automatic rel();
    i_req_valid = 1'b0;
    tick(1);
  endtask
  task automatic get_rd(input logic exp);
    for (int n = 0; n < 500 && rd_q.size() == 0; n++) tick(1);
    chk(rd_q.size() > 0, 1'b1);
    if (rd_q.size() > 0) chk(rd_q.pop_front(), exp);
  endtask
  task automatic t_init();
    chk(o_init_done, 1'b0);
    tick(18);
    chk(mem_u.ras_count, 0);
    for (int n = 0; n < 1000 && o_init_done !== 1'b1; n++) tick(1);
    chk(o_init_done, 1'b1);
    chk(mem_u.ras_count, INIT_ROW_CYCLES);
    chk(mem_u.row_only >= 8, 1'b1);
    chk(rd_q.size(), 0);
  endtask
  task automatic t_wr();
    send(1'b1, 1'b0, 1'b0, ADR_A, 1'b1);
    send(1'b0, 1'b0, 1'b0, ADR_A, 1'b0);
    send(1'b0, 1'b0, 1'b0, ADR_A ^ 18'h00001, 1'b1);
    rel();
    get_rd(1'b1);
    get_rd(1'b0);
    chk(mem_u.mem[ADR_A], 1'b1);
    chk(mem_u.mem[{ADR_A[8:0], ADR_A[17:9]}], 1'b0);
  endtask
  task automatic t_rmw();
    send(1'b0, 1'b1, 1'b0, ADR_A, 1'b0);
    rel();
    get_rd(1'b1);
    send(1'b0, 1'b0, 1'b0, ADR_A, 1'b0);
    rel();
    get_rd(1'b0);
    chk(mem_u.mem[ADR_A], 1'b0);
  endtask
  task automatic t_page();
    send(1'b1, 1'b0, 1'b0, ADR_C, 1'b1);
    send(1'b1, 1'b0, 1'b1, ADR_C + 18'h2, 1'b1);
    send(1'b0, 1'b0, 1'b0, ADR_C, 1'b0);
    send(1'b0, 1'b0, 1'b1, ADR_C + 18'h1, 1'b0);
    send(1'b0, 1'b0, 1'b1, ADR_C + 18'h2, 1'b0);
    rel();
    get_rd(1'b1);
    get_rd(1'b0);
    get_rd(1'b1);
  endtask
  task automatic t_ref();
    int r;
    r = mem_u.row_only;
    tick(600);
    chk(mem_u.row_only - r >= 2, 1'b1);
    chk(rd_q.size(), 0);
  endtask
  initial begin
    tick(4);
    i_rst_n = 1'b1;
    t_init();
    t_wr();
    t_rmw();
    t_page();
    t_ref();
    test_done();
  end
endmodule
